// File: run_cmd_pkg.sv
// package: constants and types for the run command source decoder
package run_cmd_pkg;

    // ------------------------------------------------------------
    // channel, mode and function codes
    // ------------------------------------------------------------
    localparam int NUM_INPUTS = 9;
    localparam logic [1:0] CHAN_KEYPAD = 2'h0;
    localparam logic [1:0] CHAN_TERMINAL = 2'h1;
    localparam logic [1:0] CHAN_COMM = 2'h2;
    localparam logic [1:0] MODE_TWO_WIRE_1 = 2'h0;
    localparam logic [1:0] MODE_TWO_WIRE_2 = 2'h1;
    localparam logic [1:0] MODE_THREE_WIRE_1 = 2'h2;
    localparam logic [1:0] MODE_THREE_WIRE_2 = 2'h3;
    localparam logic [6:0] FUNC_NONE = 7'h00;
    localparam logic [6:0] FUNC_FWD_RUN = 7'h01;
    localparam logic [6:0] FUNC_REV_RUN = 7'h02;
    localparam logic [6:0] FUNC_THREE_WIRE = 7'h03;
    localparam logic [6:0] FUNC_FWD_JOG = 7'h04;
    localparam logic [6:0] FUNC_REV_JOG = 7'h05;
    localparam logic [6:0] FUNC_COAST = 7'h06;
    localparam logic [6:0] FUNC_FAULT_RESET = 7'h07;
    localparam logic [6:0] FUNC_MAX = 7'h5F;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic RUN_RESET = 1'b0;
    localparam logic DIR_RESET = 1'b0;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef logic [6:0] func_code_t;

    typedef struct packed {
        logic forward_input;
        logic reverse_input;
        logic enable3;
        logic jogFwd;
        logic jogRev;
        logic coast;
        logic faultReset;
    } func_levels_t;

    typedef struct packed {
        logic run;
        logic reverse;
        logic jogFwd;
        logic jogRev;
        logic coast;
        logic faultReset;
    } run_cmd_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic reverse;
    } comm_cmd_t;

endpackage

// File: input_sync.sv
// module: two-stage synchroniser plus edge detection for the terminal inputs
module input_sync #(
    parameter int WIDTH = 9
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // raw pins and synchronised view
    input wire logic [WIDTH-1:0] pinRaw,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] prev;
    } sync_state_t;

    sync_state_t st_q;
    sync_state_t st_d;

    // meta is read only by sync; edges compare sync against prev
    always_comb begin
        st_d = st_q;
        st_d.meta = pinRaw;
        st_d.sync = st_q.meta;
        st_d.prev = st_q.sync;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // edges from registered samples only
    assign level = st_q.sync;
    assign rise = st_q.sync & ~st_q.prev;
    assign fall = ~st_q.sync & st_q.prev;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_rise_edge;
        @(posedge clk) disable iff (rst) |rise |-> (level != $past(level));
    endproperty
    a_rise_edge: assert property (p_rise_edge) else $error("rise without level change");

    property p_sync_delay;
        @(posedge clk) disable iff (rst) ##2 1'b1 |-> level == $past(pinRaw, 2);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("sync delay not two cycles");
endmodule

// File: run_command_source_decoder.sv
// module: run command source selection and terminal decoding
// Operation
// - run source from channel select: 0 keypad, 1 terminals, 2 serial link
// - keypad source: run key starts drive, running indicator on
// - keypad source while running: stop key stops drive, indicator off
// - each of nine inputs has own function code 0 to 95
// - codes: 1 fwd, 2 rev, 3 three-wire enable, 4/5 jog, 6 coast, 7 reset
// - mode field 0..3: two-wire 1, two-wire 2, three-wire 1, three-wire 2
// - two-wire 1: off/off stop, fwd forward, rev reverse, both hold
// - two-wire 2: fwd enables run, rev picks direction
// - three-wire 1: fwd rising edge starts, rev level sets direction; enable off stops
// - three-wire 1 running: each rev edge inverts direction
// - three-wire 2: fwd edge runs forward, rev edge runs reverse; enable off stops
// - two-wire: after an external stop, restart only on fresh fwd/rev assertion (fwd alone in two-wire 2)
// - comm source: start and stop come from the serial link commands
module run_command_source_decoder
    import run_cmd_pkg::*;
#(
    parameter int NUM_IN = 9
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // configuration
    input wire logic [1:0] runCmdChannelSel,
    input wire logic [1:0] terminalCtrlMode,
    input wire run_cmd_pkg::func_code_t inputFunctionSel [NUM_IN],
    // terminal pins: multifunction_inputs then high_speed_input_a
    input wire logic [NUM_IN-1:0] multifunctionInputs,
    // keypad keys, one-cycle pulses
    input wire logic runKey,
    input wire logic stopKey,
    // serial link command strobes
    input wire run_cmd_pkg::comm_cmd_t commCmd,
    // stop from another source (coast, plc, fixed length)
    input wire logic extStop,
    // decoded outputs
    output run_cmd_pkg::run_cmd_t runCmd,
    output logic runIndicator,
    output logic badFuncCode
);
    import run_cmd_pkg::*;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // an input counts for a function when its code names that function
    function automatic logic hasFunc(input func_code_t code, input func_code_t want);
        hasFunc = (code == want);
    endfunction

    typedef struct packed {
        logic running;
        logic reverse;
        logic lockout;
        logic jogFwd;
        logic jogRev;
        logic coast;
        logic faultReset;
        logic badCode;
    } dec_state_t;

    dec_state_t st_q;
    dec_state_t st_d;

    logic [NUM_IN-1:0] lvl;
    logic [NUM_IN-1:0] riseIn;
    logic [NUM_IN-1:0] fallIn;
    func_levels_t fLvl;
    func_levels_t fRise;
    func_levels_t fFall;
    logic anyBad;

    // ------------------------------------------------------------
    // synchroniser
    // ------------------------------------------------------------
    input_sync #(
        .WIDTH(NUM_IN)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .pinRaw(multifunctionInputs),
        .level(lvl),
        .rise(riseIn),
        .fall(fallIn)
    );

    // gather levels and edges per function across all inputs
    always_comb begin
        fLvl = '0;
        fRise = '0;
        fFall = '0;
        anyBad = 1'b0;
        for (int i = 0; i < NUM_IN; i++) begin
            anyBad = anyBad | (inputFunctionSel[i] > FUNC_MAX);
            if (hasFunc(inputFunctionSel[i], FUNC_FWD_RUN)) begin
                fLvl.forward_input = fLvl.forward_input | lvl[i];
                fRise.forward_input = fRise.forward_input | riseIn[i];
                fFall.forward_input = fFall.forward_input | fallIn[i];
            end
            if (hasFunc(inputFunctionSel[i], FUNC_REV_RUN)) begin
                fLvl.reverse_input = fLvl.reverse_input | lvl[i];
                fRise.reverse_input = fRise.reverse_input | riseIn[i];
                fFall.reverse_input = fFall.reverse_input | fallIn[i];
            end
            if (hasFunc(inputFunctionSel[i], FUNC_THREE_WIRE)) begin
                fLvl.enable3 = fLvl.enable3 | lvl[i];
            end
            if (hasFunc(inputFunctionSel[i], FUNC_FWD_JOG)) begin
                fLvl.jogFwd = fLvl.jogFwd | lvl[i];
            end
            if (hasFunc(inputFunctionSel[i], FUNC_REV_JOG)) begin
                fLvl.jogRev = fLvl.jogRev | lvl[i];
            end
            if (hasFunc(inputFunctionSel[i], FUNC_COAST)) begin
                fLvl.coast = fLvl.coast | lvl[i];
            end
            if (hasFunc(inputFunctionSel[i], FUNC_FAULT_RESET)) begin
                fRise.faultReset = fRise.faultReset | riseIn[i];
            end
        end
    end

    // ------------------------------------------------------------
    // run state machine, one branch per source
    // ------------------------------------------------------------
    // the lockout bit carries a two-wire stop across until the terminal
    // re-asserts, so a stale level never restarts the motor by itself
    always_comb begin
        st_d = st_q;
        st_d.badCode = anyBad;
        st_d.jogFwd = 1'b0;
        st_d.jogRev = 1'b0;
        st_d.coast = 1'b0;
        st_d.faultReset = 1'b0;
        case (runCmdChannelSel)
            CHAN_KEYPAD: begin
                st_d.lockout = 1'b0;
                if (stopKey && st_q.running) begin
                    st_d.running = 1'b0;
                end else if (runKey) begin
                    st_d.running = 1'b1;
                end
            end
            CHAN_TERMINAL: begin
                st_d.jogFwd = fLvl.jogFwd;
                st_d.jogRev = fLvl.jogRev;
                st_d.coast = fLvl.coast;
                st_d.faultReset = fRise.faultReset;
                case (terminalCtrlMode)
                    MODE_TWO_WIRE_1: begin
                        if (fRise.forward_input || fRise.reverse_input || (!fLvl.forward_input && !fLvl.reverse_input)) begin
                            st_d.lockout = 1'b0;
                        end
                        if (!fLvl.forward_input && !fLvl.reverse_input) begin
                            st_d.running = 1'b0;
                        end else if (fLvl.forward_input && !fLvl.reverse_input && !st_d.lockout) begin
                            st_d.running = 1'b1;
                            st_d.reverse = 1'b0;
                        end else if (!fLvl.forward_input && fLvl.reverse_input && !st_d.lockout) begin
                            st_d.running = 1'b1;
                            st_d.reverse = 1'b1;
                        end
                    end
                    MODE_TWO_WIRE_2: begin
                        if (fRise.forward_input || !fLvl.forward_input) begin
                            st_d.lockout = 1'b0;
                        end
                        if (!fLvl.forward_input) begin
                            st_d.running = 1'b0;
                        end else if (!st_d.lockout) begin
                            st_d.running = 1'b1;
                            st_d.reverse = fLvl.reverse_input;
                        end
                    end
                    MODE_THREE_WIRE_1: begin
                        st_d.lockout = 1'b0;
                        if (!fLvl.enable3) begin
                            st_d.running = 1'b0;
                        end else if (fRise.forward_input && !st_q.running) begin
                            st_d.running = 1'b1;
                            st_d.reverse = fLvl.reverse_input;
                        end else if (st_q.running && (fRise.reverse_input || fFall.reverse_input)) begin
                            st_d.reverse = ~st_q.reverse;
                        end
                    end
                    MODE_THREE_WIRE_2: begin
                        st_d.lockout = 1'b0;
                        if (!fLvl.enable3) begin
                            st_d.running = 1'b0;
                        end else if (fRise.forward_input) begin
                            st_d.running = 1'b1;
                            st_d.reverse = 1'b0;
                        end else if (fRise.reverse_input) begin
                            st_d.running = 1'b1;
                            st_d.reverse = 1'b1;
                        end
                    end
                    default: begin
                        st_d.running = 1'b0;
                    end
                endcase
            end
            CHAN_COMM: begin
                st_d.lockout = 1'b0;
                if (commCmd.stop) begin
                    st_d.running = 1'b0;
                end else if (commCmd.start) begin
                    st_d.running = 1'b1;
                    st_d.reverse = commCmd.reverse;
                end
            end
            default: begin
                // unused channel code: hold the drive stopped
                st_d.running = 1'b0;
            end
        endcase
        // an external stop always wins; two-wire modes then need a fresh edge
        if (extStop) begin
            st_d.running = 1'b0;
            st_d.lockout = (runCmdChannelSel == CHAN_TERMINAL)
                && (terminalCtrlMode == MODE_TWO_WIRE_1 || terminalCtrlMode == MODE_TWO_WIRE_2);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= '{running: RUN_RESET, reverse: DIR_RESET, default: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // outputs, all registered
    // ------------------------------------------------------------
    // one assignment for the whole struct, so the output has a single driver
    assign runCmd = '{run: st_q.running, reverse: st_q.reverse, jogFwd: st_q.jogFwd, jogRev: st_q.jogRev,
        coast: st_q.coast, faultReset: st_q.faultReset};
    assign runIndicator = st_q.running;
    assign badFuncCode = st_q.badCode;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_key_start;
        @(posedge clk) disable iff (rst)
            (runCmdChannelSel == CHAN_KEYPAD && runKey && !stopKey && !extStop) |=> runIndicator;
    endproperty
    a_key_start: assert property (p_key_start) else $error("run key did not start");

    property p_key_stop;
        @(posedge clk) disable iff (rst)
            (runCmdChannelSel == CHAN_KEYPAD && stopKey && runIndicator) |=> !runIndicator;
    endproperty
    a_key_stop: assert property (p_key_stop) else $error("stop key did not stop");

    property p_two1_stop;
        @(posedge clk) disable iff (rst)
            (runCmdChannelSel == CHAN_TERMINAL && terminalCtrlMode == MODE_TWO_WIRE_1
             && !fLvl.forward_input && !fLvl.reverse_input) |=> !runCmd.run;
    endproperty
    a_two1_stop: assert property (p_two1_stop) else $error("two-wire 1 did not stop");

    property p_two2_dir;
        @(posedge clk) disable iff (rst)
            (runCmdChannelSel == CHAN_TERMINAL && terminalCtrlMode == MODE_TWO_WIRE_2
             && fLvl.forward_input && !st_q.lockout && !extStop) |=> (runCmd.run && runCmd.reverse == $past(fLvl.reverse_input));
    endproperty
    a_two2_dir: assert property (p_two2_dir) else $error("two-wire 2 direction wrong");

    property p_three_off;
        @(posedge clk) disable iff (rst)
            (runCmdChannelSel == CHAN_TERMINAL && terminalCtrlMode[1] && !fLvl.enable3) |=> !runCmd.run;
    endproperty
    a_three_off: assert property (p_three_off) else $error("three-wire enable off did not stop");

    property p_three1_flip;
        @(posedge clk) disable iff (rst)
            (runCmdChannelSel == CHAN_TERMINAL && terminalCtrlMode == MODE_THREE_WIRE_1 && fLvl.enable3
             && runCmd.run && (fRise.reverse_input || fFall.reverse_input) && !extStop) |=> (runCmd.reverse != $past(runCmd.reverse));
    endproperty
    a_three1_flip: assert property (p_three1_flip) else $error("reverse edge did not invert");

    property p_three2_rev;
        @(posedge clk) disable iff (rst)
            (runCmdChannelSel == CHAN_TERMINAL && terminalCtrlMode == MODE_THREE_WIRE_2 && fLvl.enable3
             && fRise.reverse_input && !fRise.forward_input && !extStop) |=> (runCmd.run && runCmd.reverse);
    endproperty
    a_three2_rev: assert property (p_three2_rev) else $error("reverse edge did not run reverse");

    property p_lockout;
        @(posedge clk) disable iff (rst)
            (runCmdChannelSel == CHAN_TERMINAL && !terminalCtrlMode[1] && extStop)
            ##1 (!fRise.forward_input && !fRise.reverse_input && !extStop) |=> !runCmd.run;
    endproperty
    a_lockout: assert property (p_lockout) else $error("restart without new edge");

    property p_comm;
        @(posedge clk) disable iff (rst)
            (runCmdChannelSel == CHAN_COMM && commCmd.start && !commCmd.stop && !extStop) |=> runCmd.run;
    endproperty
    a_comm: assert property (p_comm) else $error("link start ignored");

    property p_source_only;
        @(posedge clk) disable iff (rst)
            (runCmdChannelSel != CHAN_KEYPAD && !runCmd.run && runCmdChannelSel != CHAN_TERMINAL
             && !commCmd.start) |=> !runCmd.run;
    endproperty
    a_source_only: assert property (p_source_only) else $error("start from unselected source");

    c_key_run: cover property (@(posedge clk) disable iff (rst) runCmdChannelSel == CHAN_KEYPAD && runKey);
    c_three1_flip: cover property (@(posedge clk) disable iff (rst)
        terminalCtrlMode == MODE_THREE_WIRE_1 && runCmd.run ##1 runCmd.reverse != $past(runCmd.reverse));
    c_lockout: cover property (@(posedge clk) disable iff (rst) st_q.lockout && fLvl.forward_input);
    c_comm_run: cover property (@(posedge clk) disable iff (rst) runCmdChannelSel == CHAN_COMM && runCmd.run);
endmodule

// File: panel_model.sv
// partner model: operator keypad keys and terminal switches
module panel_model (
    // clock
    input wire logic clk,
    // keypad keys, active high
    output logic runKey,
    output logic stopKey,
    // terminal switches, closed = 1
    output logic [8:0] pins
);
    timeunit 1ns;
    timeprecision 100ps;

    // keys released and switches open at power up
    initial begin
        runKey = 1'b0;
        stopKey = 1'b0;
        pins = 9'h000;
    end

    // ------------------------------------------------------------
    // key presses and switch changes
    // ------------------------------------------------------------
    // a press is one clock wide and launched on a falling edge, so the
    // design sees it at exactly one rising edge
    task automatic press(input logic isStop);
        @(negedge clk);
        if (isStop) begin
            stopKey = 1'b1;
        end else begin
            runKey = 1'b1;
        end
        @(negedge clk);
        runKey = 1'b0;
        stopKey = 1'b0;
    endtask

    // switches are levels; contacts move between clock edges like a real
    // asynchronous input would
    task automatic set_pins(input logic [8:0] v);
        @(negedge clk);
        pins = v;
    endtask
endmodule

// File: testbench.sv
// testbench: run command source decoder driven by the keypad and terminal model
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import run_cmd_pkg::*;

    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] mode;
        logic [8:0] pins;
        run_cmd_t exp;
    } row_t;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] runCmdChannelSel = CHAN_TERMINAL;
    logic [1:0] terminalCtrlMode = MODE_TWO_WIRE_1;
    // input 7 is spare so that it can be re-coded at run time
    func_code_t inputFunctionSel [NUM_INPUTS] = '{FUNC_FWD_RUN, FUNC_REV_RUN, FUNC_THREE_WIRE, FUNC_FWD_JOG,
        FUNC_REV_JOG, FUNC_COAST, FUNC_FAULT_RESET, FUNC_NONE, FUNC_FWD_RUN};
    comm_cmd_t commCmd = 3'h0;
    logic extStop = 1'b0;
    logic [8:0] pins;
    logic runKey;
    logic stopKey;
    run_cmd_t runCmd;
    logic runIndicator;
    logic badFuncCode;
    int errorCnt = 0;
    int compares = 0;

    // free running 100 MHz clock
    always #5 clk = ~clk;

    panel_model u_panel (.clk(clk), .runKey(runKey), .stopKey(stopKey), .pins(pins));

    run_command_source_decoder #(.NUM_IN(NUM_INPUTS)) u_dut (
        .clk(clk),
        .rst(rst),
        .runCmdChannelSel(runCmdChannelSel),
        .terminalCtrlMode(terminalCtrlMode),
        .inputFunctionSel(inputFunctionSel),
        .multifunctionInputs(pins),
        .runKey(runKey),
        .stopKey(stopKey),
        .commCmd(commCmd),
        .extStop(extStop),
        .runCmd(runCmd),
        .runIndicator(runIndicator),
        .badFuncCode(badFuncCode)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic row_t mk(input logic [1:0] m, input logic [8:0] p, input run_cmd_t e);
        return '{m, p, e};
    endfunction

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // the indicator must always mirror the run bit, so both are checked together
    task automatic chk_cmd(input run_cmd_t exp, input string msg);
        compares++;
        if (runCmd !== exp || runIndicator !== exp.run) begin
            errorCnt++;
            $display("wrong value at %0t: %s got %h", $time, msg, runCmd);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        compares++;
        if (got !== exp) begin
            errorCnt++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    // link strobes last one cycle, like a decoded frame would give
    task automatic comm_pulse(input comm_cmd_t c);
        @(negedge clk);
        commCmd = c;
        @(negedge clk);
        commCmd = 3'h0;
    endtask

    task automatic wrap_up();
        $display("compares %0d errors %0d", compares, errorCnt);
        if (errorCnt == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        row_t rows[$];
        int fr;
        // a stopped drive keeps its last direction, so stops after reverse running read 6'h10
        rows = '{mk(2'h0, 9'h000, 6'h00), mk(2'h0, 9'h001, 6'h20), mk(2'h0, 9'h003, 6'h20),
            mk(2'h0, 9'h002, 6'h30), mk(2'h0, 9'h003, 6'h30), mk(2'h0, 9'h000, 6'h10),
            mk(2'h1, 9'h001, 6'h20), mk(2'h1, 9'h003, 6'h30), mk(2'h1, 9'h002, 6'h10),
            mk(2'h1, 9'h000, 6'h10), mk(2'h0, 9'h100, 6'h20), mk(2'h0, 9'h000, 6'h00),
            mk(2'h0, 9'h008, 6'h08), mk(2'h0, 9'h010, 6'h04), mk(2'h0, 9'h020, 6'h02),
            mk(2'h0, 9'h000, 6'h00), mk(2'h2, 9'h004, 6'h00), mk(2'h2, 9'h005, 6'h20),
            mk(2'h2, 9'h007, 6'h30), mk(2'h2, 9'h005, 6'h20), mk(2'h2, 9'h001, 6'h00),
            mk(2'h2, 9'h004, 6'h00), mk(2'h2, 9'h006, 6'h00), mk(2'h2, 9'h007, 6'h30),
            mk(2'h2, 9'h003, 6'h10), mk(2'h2, 9'h000, 6'h10), mk(2'h3, 9'h004, 6'h10),
            mk(2'h3, 9'h005, 6'h20), mk(2'h3, 9'h007, 6'h30), mk(2'h3, 9'h006, 6'h30),
            mk(2'h3, 9'h007, 6'h20), mk(2'h3, 9'h003, 6'h00), mk(2'h0, 9'h000, 6'h00)};
        wait_cyc(6);
        rst = 1'b0;
        wait_cyc(1);
        chk_cmd(6'h00, "state after reset");
        chk_bit(badFuncCode, 1'b0, "code flag after reset");
        // terminal table: all four modes and the run, enable, jog and coast inputs in sequence
        foreach (rows[i]) begin
            terminalCtrlMode = rows[i].mode;
            u_panel.set_pins(rows[i].pins);
            wait_cyc(6);
            chk_cmd(rows[i].exp, $sformatf("row %0d", i));
        end
        // fault reset is a single pulse however long the input stays closed
        terminalCtrlMode = MODE_TWO_WIRE_1;
        u_panel.set_pins(9'h040);
        fr = 0;
        repeat (8) begin
            @(negedge clk);
            fr += (runCmd.faultReset === 1'b1) ? 1 : 0;
        end
        chk_bit(fr == 1, 1'b1, "fault reset pulse width");
        // an outside stop locks out the still-closed forward switch
        u_panel.set_pins(9'h001);
        wait_cyc(6);
        extStop = 1'b1;
        wait_cyc(1);
        extStop = 1'b0;
        wait_cyc(6);
        chk_cmd(6'h00, "restart without new edge");
        u_panel.set_pins(9'h000);
        wait_cyc(4);
        u_panel.set_pins(9'h001);
        wait_cyc(1);
        chk_cmd(6'h00, "pin seen before synchroniser");
        wait_cyc(5);
        chk_cmd(6'h20, "restart after new edge");
        u_panel.set_pins(9'h000);
        wait_cyc(6);
        // a re-coded spare input takes its new meaning
        inputFunctionSel[7] = FUNC_REV_RUN;
        u_panel.set_pins(9'h080);
        wait_cyc(6);
        chk_cmd(6'h30, "re-coded input");
        u_panel.set_pins(9'h000);
        inputFunctionSel[7] = 7'h60;
        wait_cyc(6);
        chk_bit(badFuncCode, 1'b1, "code above range");
        inputFunctionSel[7] = FUNC_MAX;
        wait_cyc(3);
        chk_bit(badFuncCode, 1'b0, "top legal code");
        // every input moved to another function at once
        inputFunctionSel = '{FUNC_REV_RUN, FUNC_FWD_RUN, FUNC_NONE, FUNC_THREE_WIRE, FUNC_COAST, FUNC_FWD_JOG,
            FUNC_REV_JOG, FUNC_FAULT_RESET, FUNC_REV_RUN};
        u_panel.set_pins(9'h001);
        wait_cyc(6);
        chk_cmd(6'h30, "remapped input 0 runs reverse");
        u_panel.set_pins(9'h022);
        wait_cyc(6);
        chk_cmd(6'h28, "remapped forward and jog");
        u_panel.set_pins(9'h000);
        wait_cyc(6);
        // keys only count on the keypad channel, link strobes only on the link
        u_panel.press(1'b0);
        wait_cyc(2);
        chk_cmd(6'h00, "run key on terminal channel");
        runCmdChannelSel = CHAN_KEYPAD;
        u_panel.press(1'b0);
        wait_cyc(2);
        chk_cmd(6'h20, "run key");
        comm_pulse(3'h2);
        wait_cyc(2);
        chk_cmd(6'h20, "link stop on keypad channel");
        u_panel.press(1'b1);
        wait_cyc(2);
        chk_cmd(6'h00, "stop key");
        comm_pulse(3'h4);
        wait_cyc(2);
        chk_cmd(6'h00, "link start on keypad channel");
        runCmdChannelSel = CHAN_COMM;
        comm_pulse(3'h4);
        wait_cyc(2);
        chk_cmd(6'h20, "link start");
        u_panel.press(1'b1);
        wait_cyc(2);
        chk_cmd(6'h20, "stop key on link channel");
        comm_pulse(3'h6);
        wait_cyc(2);
        chk_cmd(6'h00, "link stop with start");
        comm_pulse(3'h5);
        wait_cyc(2);
        chk_cmd(6'h30, "link start in reverse");
        // reset in mid-run drops the drive at once, without waiting for a clock
        rst = 1'b1;
        #1;
        chk_cmd(6'h00, "asynchronous reset while running");
        wait_cyc(2);
        rst = 1'b0;
        wait_cyc(2);
        chk_cmd(6'h00, "state after second reset");
        comm_pulse(3'h4);
        wait_cyc(2);
        chk_cmd(6'h20, "link start after second reset");
        runCmdChannelSel = 2'h3;
        wait_cyc(2);
        chk_cmd(6'h00, "spare channel code holds the drive stopped");
        wrap_up();
    end

    // watchdog: the sequence needs well under ten microseconds
    initial begin
        #50us;
        errorCnt++;
        $display("wrong value at %0t: watchdog expired", $time);
        wrap_up();
    end
endmodule
